// ===== rtl/acwpm_pkg.sv
/*
  Shared constants and types for the converter control-word write path
  and power-mode sequencer. Assumes a 20 MHz aclk and an AXI4-Lite host.
*/
package acwpm_pkg;
  localparam int CTRL_W = 12;
  localparam int PM_LO_POS = 4;
  localparam int PM_HI_POS = 5;
  localparam int HBS_POS = 8;
  localparam logic [11:0] CTRL_RST = 12'h000;

  localparam int CLK_PERIOD_NS = 50;
  localparam int T_PWRUP_MS = 10;
  localparam int T_STBY_EXT_NS = 600;
  localparam int T_STBY_INT_US = 7;
  localparam int PWRUP_CYC = (T_PWRUP_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STBY_EXT_CYC = (T_STBY_EXT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STBY_INT_CYC = (T_STBY_INT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYC = 14;
  localparam int CNT_W = 18;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_EVT = 8'h0c;
  localparam int CFG_INTREF_POS = 0;
  localparam logic CFG_INTREF_RST = 1'b1;
  localparam int EVT_EARLY_POS = 0;
  localparam int EVT_DONE_POS = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PM_NORMAL = 2'b00,
    PM_AUTO_SD = 2'b01,
    PM_AUTO_STBY = 2'b10,
    PM_FULL_SD = 2'b11
  } acwpm_pm_e;

  typedef enum logic [2:0] {
    ST_INIT_HOLD = 3'b000,
    ST_READY = 3'b001,
    ST_CONVERT = 3'b010,
    ST_POWERUP = 3'b011,
    ST_AUTO_SD = 3'b100,
    ST_STANDBY = 3'b101,
    ST_FULL_SD = 3'b110
  } acwpm_state_e;

  typedef struct packed {
    logic [20:0] zero;
    logic low_pending;
    logic word_mode;
    logic powered;
    logic ready;
    logic track;
    logic busy;
    logic [1:0] pm;
    logic [2:0] state;
  } acwpm_status_s;
endpackage : acwpm_pkg

// ===== rtl/acwpm_top.sv
/*
  Control-word write port and power-mode sequencer of a sampling converter,
  with an AXI4-Lite register slave. Assumes parallel-port pins are async to
  aclk and each write strobe lasts several aclk periods.
*/
// Contract
// - word mode: one write loads all twelve data lines, lowest line is bit 0
// - byte mode: two writes on low eight lines, shared line picks the half
// - written data is captured on the rising edge of the write strobe
// - chip select and write strobe gated; write only while both are low
// - two power bits pick one of four modes; reset selects normal
// - after reset track/hold holds until first convert_start_n rising edge
// - normal mode stays powered between conversions, no wait
// - auto-shutdown powers down and holds at end of each conversion
// - auto-shutdown: rising edge starts power-up and tracking; wait 10 ms
// - auto-standby: standby and hold at end of each conversion
// - auto-standby: rising edge wakes and tracks; wait 600 ns or 7 us
// - full shutdown write powers down and holds at write strobe rise
// - normal-mode write in full shutdown powers up and tracks; wait 10 ms
// - convert_start_n falling edge starts conversion; busy high throughout
// - twelve-bit port; static word_byte_select high word, low byte
`timescale 1ns/1ps
module acwpm_top #(
  parameter int PWRUP_CYC = acwpm_pkg::PWRUP_CYC,
  parameter int CONV_CYC = acwpm_pkg::CONV_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic word_byte_select,
  input wire logic [11:0] parallel_data_lines,
  input wire logic convert_start_n,
  output logic busy,
  output logic track_mode,
  output logic powered_up,
  output logic conv_ready,
  output logic [11:0] ctrl_word
);
  function automatic logic [acwpm_pkg::CNT_W-1:0] to_cnt(input int cyc);
    to_cnt = acwpm_pkg::CNT_W'(cyc);
  endfunction : to_cnt

  // pin synchronisers, two stages each
  logic [15:0] pin_s1_r;
  logic [15:0] pin_s2_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_r <= 16'hf000;
      pin_s2_r <= 16'hf000;
    end else begin
      pin_s1_r <= {chip_select_n, write_strobe_n, word_byte_select,
                   convert_start_n, parallel_data_lines};
      pin_s2_r <= pin_s1_r;
    end
  end

  logic cs_n_s;
  logic wr_n_s;
  logic wbs_s;
  logic cst_s;
  logic [11:0] data_s;
  assign {cs_n_s, wr_n_s, wbs_s, cst_s, data_s} = pin_s2_r;

  logic wr_act;
  assign wr_act = !cs_n_s && !wr_n_s;

  logic wr_act_d_r;
  logic cst_d_r;
  logic [11:0] data_hold_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_act_d_r <= 1'b0;
      cst_d_r <= 1'b1;
      data_hold_r <= 12'h000;
    end else begin
      wr_act_d_r <= wr_act;
      cst_d_r <= cst_s;
      if (wr_act) begin
        data_hold_r <= data_s; // last value seen while chip select and strobe low
      end
    end
  end

  logic wr_done;
  logic cst_rise;
  logic cst_fall;
  assign wr_done = wr_act_d_r && !wr_act;
  assign cst_rise = cst_s && !cst_d_r;
  assign cst_fall = !cst_s && cst_d_r;

  // control word assembly
  logic [7:0] low_byte_r;
  logic low_pending_r;
  logic apply_r;
  logic [11:0] ctrl_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_byte_r <= 8'h00;
      low_pending_r <= 1'b0;
      apply_r <= 1'b0;
      ctrl_r <= acwpm_pkg::CTRL_RST;
    end else begin
      apply_r <= 1'b0;
      if (wr_done) begin
        if (wbs_s) begin
          ctrl_r <= data_hold_r;
          apply_r <= 1'b1;
        end else if (data_hold_r[acwpm_pkg::HBS_POS]) begin
          ctrl_r <= {data_hold_r[3:0], low_byte_r};
          low_pending_r <= 1'b0;
          apply_r <= 1'b1;
        end else begin
          low_byte_r <= data_hold_r[7:0];
          low_pending_r <= 1'b1;
        end
      end
    end
  end

  acwpm_pkg::acwpm_pm_e pm;
  assign pm = acwpm_pkg::acwpm_pm_e'({ctrl_r[acwpm_pkg::PM_HI_POS],
                                      ctrl_r[acwpm_pkg::PM_LO_POS]});

  // register-side state
  logic intref_r;
  logic evt_early_r;
  logic evt_done_r;

  // power and conversion sequencer
  acwpm_pkg::acwpm_state_e state_r;
  logic [acwpm_pkg::CNT_W-1:0] cnt_r;
  logic conv_end;
  logic early_conv;
  assign conv_end = (state_r == acwpm_pkg::ST_CONVERT) && (cnt_r == to_cnt(1));
  assign early_conv = (state_r == acwpm_pkg::ST_POWERUP) && cst_fall;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= acwpm_pkg::ST_INIT_HOLD;
      cnt_r <= '0;
    end else if (apply_r && pm == acwpm_pkg::PM_FULL_SD) begin
      state_r <= acwpm_pkg::ST_FULL_SD;
      cnt_r <= '0;
    end else begin
      case (state_r)
        acwpm_pkg::ST_INIT_HOLD: begin
          if (cst_rise) begin
            state_r <= acwpm_pkg::ST_READY;
          end
        end
        acwpm_pkg::ST_READY: begin
          if (cst_fall) begin
            state_r <= acwpm_pkg::ST_CONVERT;
            cnt_r <= to_cnt(CONV_CYC);
          end
        end
        acwpm_pkg::ST_CONVERT: begin
          cnt_r <= cnt_r - to_cnt(1);
          if (conv_end) begin
            case (pm)
              acwpm_pkg::PM_AUTO_SD: state_r <= acwpm_pkg::ST_AUTO_SD;
              acwpm_pkg::PM_AUTO_STBY: state_r <= acwpm_pkg::ST_STANDBY;
              default: state_r <= acwpm_pkg::ST_READY;
            endcase
          end
        end
        acwpm_pkg::ST_AUTO_SD: begin
          if (cst_rise) begin
            state_r <= acwpm_pkg::ST_POWERUP;
            cnt_r <= to_cnt(PWRUP_CYC);
          end
        end
        acwpm_pkg::ST_STANDBY: begin
          if (cst_rise) begin
            state_r <= acwpm_pkg::ST_POWERUP;
            cnt_r <= intref_r ? to_cnt(acwpm_pkg::STBY_INT_CYC)
                              : to_cnt(acwpm_pkg::STBY_EXT_CYC);
          end
        end
        acwpm_pkg::ST_FULL_SD: begin
          if (apply_r) begin
            state_r <= acwpm_pkg::ST_POWERUP;
            cnt_r <= to_cnt(PWRUP_CYC);
          end
        end
        acwpm_pkg::ST_POWERUP: begin
          // falling edges here are refused, not converted
          cnt_r <= cnt_r - to_cnt(1);
          if (cnt_r == to_cnt(1)) begin
            state_r <= acwpm_pkg::ST_READY;
          end
        end
        default: begin
          state_r <= acwpm_pkg::ST_INIT_HOLD;
        end
      endcase
    end
  end

  // pin-level outputs, registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      track_mode <= 1'b0;
      powered_up <= 1'b1;
      conv_ready <= 1'b0;
      ctrl_word <= acwpm_pkg::CTRL_RST;
    end else begin
      busy <= (state_r == acwpm_pkg::ST_CONVERT) && !conv_end;
      track_mode <= (state_r == acwpm_pkg::ST_READY) ||
                    (state_r == acwpm_pkg::ST_POWERUP);
      powered_up <= (state_r != acwpm_pkg::ST_AUTO_SD) &&
                    (state_r != acwpm_pkg::ST_STANDBY) &&
                    (state_r != acwpm_pkg::ST_FULL_SD);
      conv_ready <= (state_r == acwpm_pkg::ST_READY);
      ctrl_word <= ctrl_r;
    end
  end

  // axi4-lite write channel; a low ready means that channel is held
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_write;
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= acwpm_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_r == acwpm_pkg::ADDR_CFG ||
                        awaddr_r == acwpm_pkg::ADDR_EVT) ?
                       acwpm_pkg::RESP_OKAY : acwpm_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_cfg;
  logic wr_evt;
  assign wr_cfg = do_write && awaddr_r == acwpm_pkg::ADDR_CFG && wstrb_r[0];
  assign wr_evt = do_write && awaddr_r == acwpm_pkg::ADDR_EVT && wstrb_r[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      intref_r <= acwpm_pkg::CFG_INTREF_RST;
    end else if (wr_cfg) begin
      intref_r <= wdata_r[acwpm_pkg::CFG_INTREF_POS];
    end
  end

  // sticky events, write one to clear; a new event wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_early_r <= 1'b0;
      evt_done_r <= 1'b0;
    end else begin
      evt_early_r <= early_conv ||
        (evt_early_r && !(wr_evt && wdata_r[acwpm_pkg::EVT_EARLY_POS]));
      evt_done_r <= conv_end ||
        (evt_done_r && !(wr_evt && wdata_r[acwpm_pkg::EVT_DONE_POS]));
    end
  end

  // axi4-lite read channel
  acwpm_pkg::acwpm_status_s stat;
  always_comb begin
    stat = '0;
    stat.low_pending = low_pending_r;
    stat.word_mode = wbs_s;
    stat.powered = powered_up;
    stat.ready = conv_ready;
    stat.track = track_mode;
    stat.busy = busy;
    stat.pm = pm;
    stat.state = state_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= acwpm_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= acwpm_pkg::RESP_OKAY;
      case (s_axi_araddr)
        acwpm_pkg::ADDR_CTRL: s_axi_rdata <= {20'h00000, ctrl_r};
        acwpm_pkg::ADDR_CFG: s_axi_rdata <= {31'h0000_0000, intref_r};
        acwpm_pkg::ADDR_STAT: s_axi_rdata <= stat;
        acwpm_pkg::ADDR_EVT: s_axi_rdata <= {30'h0000_0000, evt_done_r, evt_early_r};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= acwpm_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule : acwpm_top

// ===== bench/acwpm_asserts.sv
/*
  Port checker for acwpm_top: write timing, conversion and power modes.
  Assumes CONV_CYC matches the instance it is bound to.
*/
`timescale 1ns/1ps
module acwpm_asserts #(
  parameter int CONV_CYC = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic convert_start_n,
  input wire logic busy,
  input wire logic track_mode,
  input wire logic powered_up,
  input wire logic conv_ready,
  input wire logic [11:0] ctrl_word
);
  logic [7:0] bcnt_r;
  logic [7:0] qcnt_r;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    bcnt_r <= busy ? bcnt_r + 8'h01 : 8'h00;
  end
  // cycles since the gated write strobe was last active
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      qcnt_r <= 8'hff;
    end else if (!chip_select_n && !write_strobe_n) begin
      qcnt_r <= 8'h00;
    end else if (qcnt_r != 8'hff) begin
      qcnt_r <= qcnt_r + 8'h01;
    end
  end
  AST_RST_VAL: assert property ($rose(aresetn) |-> ctrl_word == 12'h000 && !track_mode)
    else $error("reset state wrong");
  AST_BUSY_HOLD: assert property (busy |-> !track_mode && !conv_ready)
    else $error("tracking during conversion");
  AST_BUSY_LEN: assert property ($fell(busy) |-> bcnt_r == CONV_CYC - 1)
    else $error("busy length wrong");
  AST_BUSY_START: assert property ($fell(convert_start_n) && conv_ready && !busy
    |-> ##[2:8] busy)
    else $error("conversion not started");
  AST_CONV_POWERED: assert property ($rose(busy) |-> powered_up)
    else $error("conversion while unpowered");
  AST_AUTO_DOWN: assert property ($fell(busy) && ctrl_word[5:4] inside {2'b01, 2'b10}
    |-> ##[0:3] (!powered_up && !track_mode))
    else $error("no power down after conversion");
  AST_FULL_SD: assert property (ctrl_word[5:4] == 2'b11 && $stable(ctrl_word)
    |-> !powered_up && !track_mode && !busy)
    else $error("full shutdown not held");
  AST_WR_APPLY: assert property ($changed(ctrl_word) |-> qcnt_r inside {[1:12]})
    else $error("control word changed without write");
  AST_WAKE: assert property ($rose(conv_ready) |-> track_mode && powered_up)
    else $error("ready while not tracking");
  cover property ($rose(busy));
  cover property (ctrl_word[5:4] == 2'b11);
  cover property ($rose(conv_ready) && ctrl_word[5:4] == 2'b01);
endmodule : acwpm_asserts

bind acwpm_top acwpm_asserts #(.CONV_CYC(CONV_CYC)) u_chk (.*);

// ===== bench/acwpm_host.sv
/*
  Parallel-port host model: write strobes and convert start.
  Assumes the bench calls its tasks just after a rising aclk edge.
*/
`timescale 1ns/1ps
module acwpm_host (
  input wire logic aclk,
  output logic chip_select_n,
  output logic write_strobe_n,
  output logic word_byte_select,
  output logic [11:0] parallel_data_lines,
  output logic convert_start_n
);
  initial begin
    chip_select_n = 1'b1;
    write_strobe_n = 1'b1;
    word_byte_select = 1'b1;
    parallel_data_lines = 12'h000;
    convert_start_n = 1'b0;
  end
  // one strobe; sel low leaves chip select idle
  task automatic pulse(input logic [11:0] d, input logic sel);
    @(posedge aclk);
    parallel_data_lines <= d;
    chip_select_n <= !sel;
    write_strobe_n <= 1'b0;
    repeat (4) @(posedge aclk);
    chip_select_n <= 1'b1;
    write_strobe_n <= 1'b1;
    @(posedge aclk);
    parallel_data_lines <= ~d; // hold time over, lines driven to the inverse of d
    repeat (8) @(posedge aclk);
  endtask : pulse
  task automatic write_ctrl(input logic [11:0] d, input logic word, input logic sel);
    @(posedge aclk);
    word_byte_select <= word;
    repeat (4) @(posedge aclk);
    if (word) begin
      pulse(d, sel);
    end else begin
      pulse({4'h0, d[7:0]}, sel);
      pulse({3'h0, 1'b1, 4'h0, d[11:8]}, sel);
    end
  endtask : write_ctrl
  task automatic start(input int gap);
    @(posedge aclk);
    convert_start_n <= 1'b1;
    repeat (gap) @(posedge aclk);
    convert_start_n <= 1'b0;
  endtask : start
endmodule : acwpm_host

// ===== bench/acwpm_top_tb.sv
/*
  Testbench for acwpm_top: AXI4-Lite tasks and a parallel-port host.
  Assumes shortened power-up and conversion counts.
*/
`timescale 1ns/1ps
module acwpm_top_tb;
  localparam int PWR = 20;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic chip_select_n, write_strobe_n, word_byte_select, convert_start_n;
  logic [11:0] parallel_data_lines;
  logic busy, track_mode, powered_up, conv_ready;
  logic [11:0] ctrl_word;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  acwpm_top #(.PWRUP_CYC(PWR), .CONV_CYC(4)) dut (.*);
  acwpm_host host (.*);
  initial forever #25 aclk = ~aclk;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, r);
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, d);
    chk(s_axi_rresp, r);
  endtask : axr
  task automatic conv(input int gap);
    host.start(gap);
    do @(posedge aclk); while (busy !== 1'b1);
    do @(posedge aclk); while (busy !== 1'b0);
    repeat (6) @(posedge aclk);
  endtask : conv
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(ctrl_word, 12'h000);
    chk(track_mode, 1'b0);
    axr(acwpm_pkg::ADDR_CTRL, 32'h0, acwpm_pkg::RESP_OKAY);
    axw(8'h10, 32'h1, acwpm_pkg::RESP_SLVERR);
    axr(8'h10, 32'h0, acwpm_pkg::RESP_SLVERR);
    axw(acwpm_pkg::ADDR_CTRL, 32'hfff, acwpm_pkg::RESP_SLVERR);
    $display("test bus done");
    conv(4);
    chk({track_mode, powered_up}, 2'b11);
    host.write_ctrl(12'h9cf, 1'b1, 1'b1);
    chk(ctrl_word, 12'h9cf);
    host.write_ctrl(12'h3ff, 1'b1, 1'b0);
    axr(acwpm_pkg::ADDR_CTRL, 32'h9cf, acwpm_pkg::RESP_OKAY);
    host.write_ctrl(12'h61a, 1'b0, 1'b1);
    chk(ctrl_word, 12'h61a);
    $display("test write done");
    conv(4);
    chk({track_mode, powered_up}, 2'b00);
    host.start(4);
    repeat (6) @(posedge aclk);
    chk({track_mode, conv_ready, busy}, 3'b100);
    axr(acwpm_pkg::ADDR_EVT, 32'h3, acwpm_pkg::RESP_OKAY);
    axw(acwpm_pkg::ADDR_EVT, 32'h3, acwpm_pkg::RESP_OKAY);
    axr(acwpm_pkg::ADDR_EVT, 32'h0, acwpm_pkg::RESP_OKAY);
    repeat (PWR) @(posedge aclk);
    chk(conv_ready, 1'b1);
    host.pulse(12'h020, 1'b1);
    chk(ctrl_word, 12'h61a);
    host.pulse(12'h100, 1'b1);
    chk(ctrl_word, 12'h020);
    $display("test auto shutdown done");
    conv(4);
    chk({track_mode, powered_up}, 2'b00);
    axw(acwpm_pkg::ADDR_CFG, 32'h0, acwpm_pkg::RESP_OKAY);
    axr(acwpm_pkg::ADDR_CFG, 32'h0, acwpm_pkg::RESP_OKAY);
    conv(40);
    chk(powered_up, 1'b0);
    axw(acwpm_pkg::ADDR_CFG, 32'h1, acwpm_pkg::RESP_OKAY);
    host.start(40);
    repeat (60) @(posedge aclk);
    chk({track_mode, conv_ready, busy}, 3'b100);
    repeat (60) @(posedge aclk);
    chk({track_mode, conv_ready, busy}, 3'b110);
    axr(acwpm_pkg::ADDR_EVT, 32'h3, acwpm_pkg::RESP_OKAY);
    host.write_ctrl(12'h030, 1'b1, 1'b1);
    chk({track_mode, powered_up}, 2'b00);
    host.write_ctrl(12'h000, 1'b1, 1'b1);
    chk({track_mode, conv_ready}, 2'b10);
    repeat (PWR) @(posedge aclk);
    chk(conv_ready, 1'b1);
    conv(4);
    chk({track_mode, powered_up}, 2'b11);
    axr(acwpm_pkg::ADDR_STAT, 32'h3c1, acwpm_pkg::RESP_OKAY);
    $display("test power modes done");
    end_of_test();
  end
endmodule : acwpm_top_tb
